// file: src/adc_sample_start_control.sv
// apb register block for converter input select, software start and pending/overrun flags
// assumes apb master on pclk; trigger and conversion-end sources are on-chip pulses
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`include "adc_ctrl_regs.svh"

// Behaviour
// - the slot 7 input of channel a follows a two-bit selector: pin, band-gap, sensor, ground.
// - the channel b slot 0 input comes from its pin or from op-amp 1 as bit 1 says.
// - the channel a slot 0 input comes from its pin or from op-amp 0 as bit 0 says.
// - a write-only start register requests a conversion per slot on each 1 written.
// - a requested conversion runs only once its group is granted by the arbiter.
// - a read-only pending flag per slot stays set until that slot's conversion ends.
// - an interrupt pulse arriving while its end flag is still set sets its overrun bit.
// - an interrupt overrun bit stays set until software writes 1 to it.
// - all these registers are zero after reset.
// - conversion end sets the source's end flag and, if enabled, raises its request.
// - a new trigger for a slot still pending sets that slot's start overrun flag.
module adc_sample_start_control #(
  parameter int CONV_CYCS = 4
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [11:0]                 paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic [15:0]                 hw_trigger,
  input  wire logic [3:0]                  irq_slot_b_match,
  output adc_ctrl_pkg::slot7_source_t      slot7_source_select,
  output adc_ctrl_pkg::slot0_source_t      group_a_slot0_source_select,
  output adc_ctrl_pkg::slot0_source_t      group_b_slot0_source_select,
  output logic                             conv_busy,
  output logic                             conv_group_b,
  output logic [2:0]                       conv_slot,
  output logic [3:0]                       conversion_irq
);
  import adc_ctrl_pkg::*;

  localparam int SLOTS = `SLOT_COUNT;
  localparam int IRQS  = `IRQ_COUNT;

  logic [3:0]        input_select_reg;
  logic [SLOTS-1:0]  start_pending_reg;
  logic [SLOTS-1:0]  start_overrun_reg;
  logic [IRQS-1:0]   irq_overrun_reg;
  logic [IRQS-1:0]   conv_end_flag_reg;
  logic [IRQS-1:0]   irq_enable_reg;
  logic [3:0]        irq_pulse;
  logic [SLOTS-1:0]  sw_start;
  logic [SLOTS-1:0]  done_vec;
  logic              conv_done;
  logic              wr_en;
  logic              rd_en;
  logic              addr_hit;

  // word-aligned register decode
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    return (a[11:2] == ofs[11:2]);
  endfunction : hit

  assign pready  = 1'b1;
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && !penable && !pwrite;
  assign addr_hit = hit(paddr, `OFS_INPUT_SOURCE_SELECT) || hit(paddr, `OFS_SOFTWARE_START) ||
                    hit(paddr, `OFS_START_PENDING) || hit(paddr, `OFS_IRQ_OVERRUN) ||
                    hit(paddr, `OFS_START_OVERRUN) || hit(paddr, `OFS_CONV_CONTROL) ||
                    hit(paddr, `OFS_CONV_END_FLAGS);
  assign pslverr = psel && penable && !addr_hit;

  assign slot7_source_select = slot7_source_t'(input_select_reg[`FLD_SLOT7_SEL_LSB +: 2]);
  assign group_b_slot0_source_select =
    slot0_source_t'(input_select_reg[`FLD_GROUP_B_SLOT0_SEL]);
  assign group_a_slot0_source_select =
    slot0_source_t'(input_select_reg[`FLD_GROUP_A_SLOT0_SEL]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_select_reg <= 4'h0;
    end else if (wr_en && hit(paddr, `OFS_INPUT_SOURCE_SELECT)) begin
      input_select_reg <= pwdata[3:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable_reg <= 4'h0;
    end else if (wr_en && hit(paddr, `OFS_CONV_CONTROL)) begin
      irq_enable_reg <= pwdata[`FLD_IRQ_ENABLE_LSB +: IRQS];
    end
  end

  assign sw_start = (wr_en && hit(paddr, `OFS_SOFTWARE_START)) ? pwdata[SLOTS-1:0] : '0;

  slot_sequencer #(
    .SLOTS     (SLOTS),
    .CONV_CYCS (CONV_CYCS)
  ) u_seq (
    .pclk         (pclk),
    .presetn      (presetn),
    .pending      (start_pending_reg),
    .conv_busy    (conv_busy),
    .conv_group_b (conv_group_b),
    .conv_slot    (conv_slot),
    .conv_done    (conv_done)
  );

  always_comb begin
    done_vec = '0;
    if (conv_done) begin
      done_vec[{conv_group_b, conv_slot}] = 1'b1;
    end
  end

  // pending set by start, cleared at end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_pending_reg <= '0;
    end else begin
      start_pending_reg <= (start_pending_reg & ~done_vec) | sw_start | hw_trigger;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_overrun_reg <= '0;
    end else begin
      start_overrun_reg <= (start_overrun_reg &
                            ~((wr_en && hit(paddr, `OFS_START_OVERRUN)) ?
                              pwdata[SLOTS-1:0] : '0)) |
                           ((sw_start | hw_trigger) & start_pending_reg & ~done_vec);
    end
  end

  // one interrupt source per slot index of group a 0..3, or b when matched
  always_comb begin
    irq_pulse = 4'h0;
    for (int i = 0; i < IRQS; i++) begin
      if (conv_done && conv_slot == 3'(i) && conv_group_b == irq_slot_b_match[i]) begin
        irq_pulse[i] = 1'b1;
      end
    end
  end

  // end flag set at conversion end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_end_flag_reg <= '0;
    end else begin
      conv_end_flag_reg <= (conv_end_flag_reg &
                            ~((wr_en && hit(paddr, `OFS_CONV_END_FLAGS)) ?
                              pwdata[IRQS-1:0] : '0)) | irq_pulse;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conversion_irq <= 4'h0;
    end else begin
      conversion_irq <= irq_pulse & irq_enable_reg;
    end
  end

  // write one to clear, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_overrun_reg <= '0;
    end else begin
      irq_overrun_reg <= (irq_overrun_reg &
                          ~((wr_en && hit(paddr, `OFS_IRQ_OVERRUN)) ?
                            pwdata[IRQS-1:0] : '0)) | (irq_pulse & conv_end_flag_reg);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `RST_ZERO;
    end else if (rd_en) begin
      prdata <= `RST_ZERO;
      if (hit(paddr, `OFS_INPUT_SOURCE_SELECT)) begin
        prdata <= {28'h0000000, input_select_reg};
      end else if (hit(paddr, `OFS_START_PENDING)) begin
        prdata <= {16'h0000, start_pending_reg};
      end else if (hit(paddr, `OFS_IRQ_OVERRUN)) begin
        prdata <= {28'h0000000, irq_overrun_reg};
      end else if (hit(paddr, `OFS_START_OVERRUN)) begin
        prdata <= {16'h0000, start_overrun_reg};
      end else if (hit(paddr, `OFS_CONV_CONTROL)) begin
        prdata <= {26'h0000000, irq_enable_reg, 2'h0};
      end else if (hit(paddr, `OFS_CONV_END_FLAGS)) begin
        prdata <= {28'h0000000, conv_end_flag_reg};
      end
    end
  end

endmodule : adc_sample_start_control

// file: src/adc_ctrl_regs.svh
// register offsets, field positions, reset values for the sample start control block
// assumes apb byte addressing, one aligned 32-bit word per register
`ifndef ADC_CTRL_REGS_SVH
`define ADC_CTRL_REGS_SVH

`define OFS_INPUT_SOURCE_SELECT 12'h044
`define OFS_SOFTWARE_START      12'h048
`define OFS_START_PENDING       12'h04c
`define OFS_IRQ_OVERRUN         12'h050
`define OFS_START_OVERRUN       12'h054
`define OFS_CONV_CONTROL        12'h040
`define OFS_CONV_END_FLAGS      12'h058

`define RST_ZERO                32'h0000_0000

`define FLD_SLOT7_SEL_LSB       2
`define FLD_GROUP_B_SLOT0_SEL   1
`define FLD_GROUP_A_SLOT0_SEL   0
`define FLD_IRQ_ENABLE_LSB      2

`define SLOT_COUNT              16
`define IRQ_COUNT               4
`define GROUP_A_LSB             0
`define GROUP_B_LSB             8

`endif

// file: src/adc_ctrl_pkg.sv
// types shared by the sample start control block
// assumes nothing outside itself
package adc_ctrl_pkg;

  // slot 7 analog source choices
  typedef enum logic [1:0] {
    src_pin      = 2'h0,
    src_bandgap  = 2'h1,
    src_temp     = 2'h2,
    src_ground   = 2'h3
  } slot7_source_t;

  // channel-level source choices
  typedef enum logic {
    slot0_pin    = 1'b0,
    slot0_opamp  = 1'b1
  } slot0_source_t;

  typedef enum logic [1:0] {
    arb_idle,
    arb_group_a,
    arb_group_b
  } arb_state_t;

endpackage : adc_ctrl_pkg

// file: src/slot_sequencer.sv
// arbitration between group a and group b pending slots
// assumes pending vector from the main block; the conversion-done pulse is made here and fed back to it
`timescale 1ns/1ps
module slot_sequencer #(
  parameter int SLOTS     = 16,
  parameter int CONV_CYCS = 4
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [SLOTS-1:0]  pending,
  output logic                   conv_busy,
  output logic                   conv_group_b,
  output logic [2:0]             conv_slot,
  output logic                   conv_done
);
  import adc_ctrl_pkg::*;

  localparam int HALF = SLOTS / 2;

  arb_state_t                state_reg;
  logic [7:0]                count_reg;
  logic                      last_b_reg;
  logic [HALF-1:0]           grp_a;
  logic [HALF-1:0]           grp_b;

  assign grp_a = pending[HALF-1:0];
  assign grp_b = pending[SLOTS-1:HALF];

  // lowest set index of an eight-bit group
  function automatic logic [2:0] first_set(input logic [HALF-1:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = HALF - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction : first_set

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg    <= arb_idle;
      count_reg    <= 8'h00;
      conv_slot    <= 3'h0;
      conv_group_b <= 1'b0;
      last_b_reg   <= 1'b1;
      conv_done    <= 1'b0;
    end else begin
      conv_done <= 1'b0;
      case (state_reg)
        arb_idle: begin
          // alternate groups when both wait
          // skip the done cycle: the finished slot is still pending then
          if (!conv_done && |grp_a && (!(|grp_b) || last_b_reg)) begin
            state_reg    <= arb_group_a;
            conv_slot    <= first_set(grp_a);
            conv_group_b <= 1'b0;
            last_b_reg   <= 1'b0;
            count_reg    <= 8'(CONV_CYCS - 1);
          end else if (!conv_done && |grp_b) begin
            state_reg    <= arb_group_b;
            conv_slot    <= first_set(grp_b);
            conv_group_b <= 1'b1;
            last_b_reg   <= 1'b1;
            count_reg    <= 8'(CONV_CYCS - 1);
          end
        end
        arb_group_a, arb_group_b: begin
          if (count_reg == 8'h00) begin
            state_reg <= arb_idle;
            conv_done <= 1'b1;
          end else begin
            count_reg <= count_reg - 8'h01;
          end
        end
        default: begin
          state_reg <= arb_idle;
        end
      endcase
    end
  end

  assign conv_busy = (state_reg != arb_idle);

endmodule : slot_sequencer

// file: testbench/adc_start_asserts.sv
// port assertions for the sample start control block
// assumes binding onto adc_sample_start_control, one clock domain
`timescale 1ns/1ps
module adc_start_asserts
  import adc_ctrl_pkg::*;
#(
  parameter int CONV_CYCS = 4
) (
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [11:0]   paddr,
  input wire logic [31:0]   pwdata,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire slot7_source_t slot7_source_select,
  input wire slot0_source_t group_a_slot0_source_select,
  input wire slot0_source_t group_b_slot0_source_select,
  input wire logic          conv_busy,
  input wire logic [3:0]    conversion_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc, mapped, sel_w;
  assign acc    = psel && penable;
  assign mapped = paddr inside {12'h040, 12'h044, 12'h048, 12'h04c, 12'h050, 12'h054, 12'h058};
  assign sel_w  = acc && pwrite && paddr == 12'h044;
  sequence conv_run;
    $rose(conv_busy) ##1 conv_busy;
  endsequence
  AST_RDY: assert property (acc |-> pready) else $error("no ready in access");
  AST_ERR: assert property (acc && !mapped |-> pslverr) else $error("unmapped not refused");
  AST_OK: assert property (acc && mapped |-> !pslverr) else $error("mapped refused");
  AST_SEL_WR: assert property (sel_w |=> slot7_source_select == $past(pwdata[3:2])
    && group_b_slot0_source_select == $past(pwdata[1])
    && group_a_slot0_source_select == $past(pwdata[0])) else $error("select not taken");
  AST_SEL_HOLD: assert property (!sel_w |=> $stable(slot7_source_select)
    && $stable(group_a_slot0_source_select) && $stable(group_b_slot0_source_select))
    else $error("select moved");
  AST_RSV: assert property (acc && !pwrite && paddr == 12'h044 |-> prdata[31:4] == 0)
    else $error("reserved select bits");
  AST_PEND: assert property (acc && !pwrite && paddr == 12'h04c |-> prdata[31:16] == 0)
    else $error("reserved pending bits");
  AST_BUSY_END: assert property (conv_run |-> ##[1:200] !conv_busy)
    else $error("conversion never ends");
  AST_IRQ_PULSE: assert property (conversion_irq[0] |=> !conversion_irq[0])
    else $error("irq longer than one cycle");
endmodule : adc_start_asserts

bind adc_sample_start_control adc_start_asserts #(.CONV_CYCS(CONV_CYCS)) i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .slot7_source_select(slot7_source_select), .conv_busy(conv_busy),
  .group_a_slot0_source_select(group_a_slot0_source_select),
  .group_b_slot0_source_select(group_b_slot0_source_select), .conversion_irq(conversion_irq));

// file: testbench/test_adc_sample_start_control.sv
// self-checking bench for the sample start control block
// assumes zero-wait apb slave; source 0 follows group a slot 0
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if (32'(g) !== 32'(e)) begin err_count++; \
  $display("[ERR] %s exp %h got %h", n, 32'(e), 32'(g)); end end
module test_adc_sample_start_control;
  import adc_ctrl_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, conv_busy, conv_group_b, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, v;
  logic [15:0] hw_trigger, rnd;
  logic [3:0]  irq_slot_b_match, conversion_irq, seen;
  logic [2:0]  conv_slot;
  slot7_source_t s7;
  slot0_source_t sa, sb;
  int err_count, n_tests, irq_n, sel_m, ovr_m, k;
  adc_sample_start_control #(.CONV_CYCS(4)) i_adc_sample_start_control (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hw_trigger(hw_trigger), .irq_slot_b_match(irq_slot_b_match),
    .slot7_source_select(s7), .group_a_slot0_source_select(sa),
    .group_b_slot0_source_select(sb), .conv_busy(conv_busy), .conv_group_b(conv_group_b),
    .conv_slot(conv_slot), .conversion_irq(conversion_irq));
  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (conv_busy === 1'b1) seen <= {conv_group_b, conv_slot};
    if (conversion_irq[0] === 1'b1) irq_n++;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task final_report;
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    i = 0;
    do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 20);
    if (i >= 20) begin err_count++; final_report(); end
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb
  task automatic conv(input int s);
    int i;
    apb(1, 12'h048, 32'h1 << s);
    apb(0, 12'h04c, 0);
    `CHK("pend_set", 32'h1 << s, rd)
    i = 0;
    do begin apb(0, 12'h04c, 0); i++; end while (rd !== 0 && i < 30);
    `CHK("pend_clr", 0, rd)
    repeat (3) @(posedge pclk);
  endtask : conv
  initial begin
    psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; presetn = 0;
    hw_trigger = 0; irq_slot_b_match = 0; rnd = 16'd17126; irq_n = 0; seen = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1;
    for (k = 0; k < 5; k++) if (k != 1) begin
      apb(0, 12'h044 + 12'(4 * k), 0);
      `CHK("reset_reg", 0, rd)
    end
    `CHK("reset_sel", 0, s7)
    $display("test reset done");
    for (k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      v = ({rnd, rnd} & ~32'hc) | (k << 2);
      apb(1, 12'h044, v);
      sel_m = v & 32'hf;
      apb(0, 12'h044, 0);
      `CHK("sel_reg", sel_m, rd)
      `CHK("slot7_sel", k, s7)
      `CHK("a0_sel", sel_m & 1, sa)
      `CHK("b0_sel", (sel_m >> 1) & 1, sb)
    end
    $display("test select done");
    apb(1, 12'h04c, 32'hffff);
    apb(1, 12'h048, 0);
    apb(0, 12'h04c, 0);
    `CHK("pend_ro", 0, rd)
    apb(1, 12'h040, 32'h3d);
    ovr_m = 0;
    for (k = 0; k < 2; k++) begin
      conv(0);
      `CHK("grant_a0", 0, seen)
      `CHK("irq_cnt", k + 1, irq_n)
      apb(0, 12'h058, 0);
      `CHK("end_flag", 1, rd & 1)
      apb(0, 12'h050, 0);
      `CHK("overrun", ovr_m, rd)
      ovr_m = 1;
    end
    apb(1, 12'h050, 0);
    apb(0, 12'h050, 0);
    `CHK("ovr_w0", 1, rd)
    apb(1, 12'h050, 1);
    apb(0, 12'h050, 0);
    `CHK("ovr_w1c", 0, rd)
    apb(1, 12'h048, 32'h4);
    @(posedge pclk) hw_trigger <= 16'h0004;
    @(posedge pclk) hw_trigger <= 16'h0000;
    apb(0, 12'h054, 0);
    `CHK("start_ovr", 32'h4, rd)
    apb(1, 12'h054, 32'h4);
    apb(0, 12'h054, 0);
    `CHK("start_ovr_w1c", 0, rd)
    conv(11);
    `CHK("grant_b3", 4'hb, seen)
    $display("test conversion done");
    apb(0, 12'h0fc, 0);
    `CHK("unmapped_err", 1, err)
    `CHK("unmapped_rd", 0, rd)
    $display("test unmapped done");
    final_report();
  end
endmodule : test_adc_sample_start_control
